// ===== rtl/scf_pkg.sv
package scf_pkg;

  // ---------------------------------------------------------------
  // clock and register bus
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned ADDR_W        = 4;
  localparam int unsigned DATA_W        = 32;

  localparam logic [3:0] SCR_OFS  = 4'h0;
  localparam logic [3:0] MASK_OFS = 4'h4;

  // ---------------------------------------------------------------
  // system control register layout
  // ---------------------------------------------------------------
  localparam int unsigned STANDBY_BIT  = 0;
  localparam int unsigned ARB_LL_BIT   = 1;
  localparam int unsigned WD_EN_BIT    = 2;
  localparam int unsigned WD_SEL_LSB   = 3;
  localparam int unsigned WD_SEL_W     = 2;
  localparam int unsigned FRZ_SEL_LSB  = 8;
  localparam int unsigned NUM_PERIPH   = 4;
  localparam int unsigned ST_STBY_BIT  = 16;
  localparam int unsigned ST_CPUD_BIT  = 17;
  localparam int unsigned ST_FRZ_BIT   = 18;
  localparam int unsigned ST_GNT_BIT   = 19;
  localparam int unsigned EVT_LSB      = 24;
  localparam int unsigned EVT_W        = 8;

  // event positions inside the top byte
  localparam int unsigned EV_WAKE    = 0;
  localparam int unsigned EV_FRZ_ON  = 1;
  localparam int unsigned EV_FRZ_OFF = 2;
  localparam int unsigned EV_CPU_DIS = 3;
  localparam int unsigned EV_WDOG    = 4;

  // peripheral slots for freeze select, hold and interrupts
  localparam int unsigned PER_MOVER  = 0;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [1:0] WD_SEL_RST  = 2'h3;
  localparam logic       WD_EN_RST   = 1'b1;
  localparam logic [3:0] FRZ_SEL_RST = 4'hf;
  localparam logic [7:0] MASK_RST    = 8'h00;

  // ---------------------------------------------------------------
  // bus watchdog timing
  // ---------------------------------------------------------------
  localparam int unsigned WD_BASE_NS  = 5120;
  localparam int unsigned WD_BASE_CYC = WD_BASE_NS / CLK_PERIOD_NS;
  localparam int unsigned WD_CNT_W    = 11;

  typedef enum logic [1:0] {
    SCF_MV_IDLE,
    SCF_MV_OWN,
    SCF_MV_DRAIN
  } scf_mover_e;

endpackage

// ===== rtl/scf_sync.sv
`timescale 1ns/1ps
module scf_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  // ---------------------------------------------------------------
  // two-stage synchroniser; the first stage feeds only the second
  // ---------------------------------------------------------------
  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= RST_VAL;
      sync_o <= RST_VAL;
    end else begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end

endmodule // scf_sync

// ===== rtl/scf_system_control.sv
`timescale 1ns/1ps
module scf_system_control (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // register port
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [31:0] reg_rdata_o,
  // pins
  input  wire logic        debug_hold_n_i,
  input  wire logic        ext_reset_n_i,
  input  wire logic        ext_halt_n_i,
  // on-chip peripherals
  input  wire logic [3:0]  periph_irq_i,
  output logic      [3:0]  periph_irq_o,
  output logic      [3:0]  periph_hold_o,
  // internal block mover
  input  wire logic        internal_block_mover_req_i,
  input  wire logic        internal_block_mover_cycle_i,
  output logic             internal_block_mover_grant_o,
  output logic             internal_block_mover_start_ok_o,
  // system bus
  input  wire logic        bus_cycle_i,
  output logic             bus_error_o,
  output logic             arb_low_latency_o,
  output logic             ext_master_sel_o,
  output logic             core_disable_o,
  output logic             core_clock_stop_o,
  output logic             irq_o
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic                           standby;
    logic                           arb_ll;
    logic                           wd_en;
    logic [scf_pkg::WD_SEL_W-1:0]   wd_sel;
    logic [scf_pkg::NUM_PERIPH-1:0] frz_sel;
    logic [scf_pkg::EVT_W-1:0]      evt;
    logic [scf_pkg::EVT_W-1:0]      mask;
    logic                           cpu_dis;
    logic                           frozen_d;
    scf_pkg::scf_mover_e            mst;
    logic [scf_pkg::WD_CNT_W-1:0]   wd_cnt;
    logic                           wd_fired;
    logic [31:0]                    rdata;
    logic                           irq;
    logic [scf_pkg::NUM_PERIPH-1:0] hold;
    logic [scf_pkg::NUM_PERIPH-1:0] irq_out;
    logic                           grant;
    logic                           start_ok;
    logic                           bus_err;
  } scf_state_s;

  scf_state_s st_r;
  scf_state_s st_nxt;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [2:0] pins_sync;
  logic       frozen;
  logic       ext_rst_act;
  logic       ext_halt_act;

  scf_sync #(
    .WIDTH   (3),
    .RST_VAL (3'h7)
  ) u_pin_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .async_i ({ext_halt_n_i, ext_reset_n_i, debug_hold_n_i}),
    .sync_o  (pins_sync)
  );

  assign frozen       = ~pins_sync[0];
  assign ext_rst_act  = ~pins_sync[1];
  assign ext_halt_act = ~pins_sync[2];

  // ---------------------------------------------------------------
  // register decode
  // ---------------------------------------------------------------
  logic                           wr_scr;
  logic                           wr_mask;
  logic [scf_pkg::EVT_W-1:0]      evt_set;
  logic [scf_pkg::EVT_W-1:0]      evt_clr;
  logic [scf_pkg::NUM_PERIPH-1:0] hold_sel;
  logic [scf_pkg::NUM_PERIPH-1:0] irq_live;
  logic                           mover_frozen;
  logic [scf_pkg::WD_CNT_W-1:0]   wd_limit;
  logic [31:0]                    scr_view;

  assign wr_scr  = reg_wr_i && (reg_addr_i == scf_pkg::SCR_OFS);
  assign wr_mask = reg_wr_i && (reg_addr_i == scf_pkg::MASK_OFS);
  assign evt_clr = wr_scr ? reg_wdata_i[scf_pkg::EVT_LSB +: scf_pkg::EVT_W] : '0;

  // freeze only reaches the peripherals that software picked
  assign hold_sel     = frozen ? st_r.frz_sel : '0;
  assign irq_live     = periph_irq_i & ~hold_sel;
  assign mover_frozen = hold_sel[scf_pkg::PER_MOVER];

  // watchdog limit doubles for each step of the select field
  assign wd_limit = scf_pkg::WD_CNT_W'(scf_pkg::WD_BASE_CYC << st_r.wd_sel);

  always_comb begin
    scr_view = '0;
    scr_view[scf_pkg::STANDBY_BIT] = st_r.standby;
    scr_view[scf_pkg::ARB_LL_BIT]  = st_r.arb_ll;
    scr_view[scf_pkg::WD_EN_BIT]   = st_r.wd_en;
    scr_view[scf_pkg::WD_SEL_LSB +: scf_pkg::WD_SEL_W]     = st_r.wd_sel;
    scr_view[scf_pkg::FRZ_SEL_LSB +: scf_pkg::NUM_PERIPH]  = st_r.frz_sel;
    scr_view[scf_pkg::ST_STBY_BIT] = st_r.standby;
    scr_view[scf_pkg::ST_CPUD_BIT] = st_r.cpu_dis;
    scr_view[scf_pkg::ST_FRZ_BIT]  = frozen;
    scr_view[scf_pkg::ST_GNT_BIT]  = st_r.grant;
    scr_view[scf_pkg::EVT_LSB +: scf_pkg::EVT_W] = st_r.evt;
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt  = st_r;
    evt_set = '0;

    // control fields
    if (wr_scr) begin
      st_nxt.arb_ll  = reg_wdata_i[scf_pkg::ARB_LL_BIT];
      st_nxt.wd_en   = reg_wdata_i[scf_pkg::WD_EN_BIT];
      st_nxt.wd_sel  = reg_wdata_i[scf_pkg::WD_SEL_LSB +: scf_pkg::WD_SEL_W];
      st_nxt.frz_sel = reg_wdata_i[scf_pkg::FRZ_SEL_LSB +: scf_pkg::NUM_PERIPH];
      if (reg_wdata_i[scf_pkg::STANDBY_BIT]) begin
        st_nxt.standby = 1'b1;
      end
    end
    if (wr_mask) begin
      st_nxt.mask = reg_wdata_i[scf_pkg::EVT_LSB +: scf_pkg::EVT_W];
    end

    // a live peripheral interrupt ends standby, even one raised
    // in the cycle that software asks for it
    if ((st_r.standby || (wr_scr && reg_wdata_i[scf_pkg::STANDBY_BIT])) && (|irq_live)) begin
      st_nxt.standby = 1'b0;
      evt_set[scf_pkg::EV_WAKE] = st_r.standby;
    end

    // core disable is sampled only while the external reset is held
    if (ext_rst_act) begin
      st_nxt.cpu_dis = ext_halt_act;
      if (ext_halt_act && !st_r.cpu_dis) begin
        evt_set[scf_pkg::EV_CPU_DIS] = 1'b1;
      end
    end

    // freeze edges
    st_nxt.frozen_d = frozen;
    if (frozen && !st_r.frozen_d) begin
      evt_set[scf_pkg::EV_FRZ_ON] = 1'b1;
    end
    if (!frozen && st_r.frozen_d) begin
      evt_set[scf_pkg::EV_FRZ_OFF] = 1'b1;
    end

    // bus watchdog: one report per stuck cycle
    st_nxt.bus_err = 1'b0;
    if (!st_r.wd_en || !bus_cycle_i) begin
      st_nxt.wd_cnt   = '0;
      st_nxt.wd_fired = 1'b0;
    end else if (!st_r.wd_fired) begin
      if (st_r.wd_cnt >= wd_limit - 1'b1) begin
        st_nxt.wd_fired = 1'b1;
        st_nxt.bus_err  = 1'b1;
        evt_set[scf_pkg::EV_WDOG] = 1'b1;
      end else begin
        st_nxt.wd_cnt = st_r.wd_cnt + 1'b1;
      end
    end

    // sticky events: a set in the clearing cycle survives
    st_nxt.evt = (st_r.evt & ~evt_clr) | evt_set;

    // block mover bus ownership
    unique case (st_r.mst)
      scf_pkg::SCF_MV_IDLE: begin
        // no new ownership while frozen; resumes on release
        if (internal_block_mover_req_i && !mover_frozen) begin
          st_nxt.mst = scf_pkg::SCF_MV_OWN;
        end
      end
      scf_pkg::SCF_MV_OWN: begin
        if (mover_frozen) begin
          // let the cycle already on the bus finish first; start_ok still shows the
          // unfrozen value on this edge, so a cycle may be launched right now as well
          st_nxt.mst = (internal_block_mover_cycle_i || (st_r.start_ok && internal_block_mover_req_i))
                       ? scf_pkg::SCF_MV_DRAIN
                       : scf_pkg::SCF_MV_IDLE;
        end else if (!internal_block_mover_req_i) begin
          st_nxt.mst = scf_pkg::SCF_MV_IDLE;
        end
      end
      scf_pkg::SCF_MV_DRAIN: begin
        if (!internal_block_mover_cycle_i) begin
          st_nxt.mst = scf_pkg::SCF_MV_IDLE;
        end
      end
    endcase
    st_nxt.grant    = (st_nxt.mst != scf_pkg::SCF_MV_IDLE);
    // grant may linger through a drain, but no fresh cycle may start
    st_nxt.start_ok = (st_nxt.mst == scf_pkg::SCF_MV_OWN) && !mover_frozen;

    // peripheral hold and gated interrupts
    st_nxt.hold    = hold_sel;
    st_nxt.irq_out = irq_live;

    // register read data, valid in the cycle after the strobe
    st_nxt.rdata = '0;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        scf_pkg::SCR_OFS:  st_nxt.rdata = scr_view;
        scf_pkg::MASK_OFS: st_nxt.rdata = {st_r.mask, 24'h000000};
        default:           st_nxt.rdata = '0;
      endcase
    end

    st_nxt.irq = |(st_nxt.evt & st_nxt.mask);
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r.standby  <= 1'b0;
      st_r.arb_ll   <= 1'b0;
      st_r.wd_en    <= scf_pkg::WD_EN_RST;
      st_r.wd_sel   <= scf_pkg::WD_SEL_RST;
      st_r.frz_sel  <= scf_pkg::FRZ_SEL_RST;
      st_r.evt      <= '0;
      st_r.mask     <= scf_pkg::MASK_RST;
      st_r.cpu_dis  <= 1'b0;
      st_r.frozen_d <= 1'b0;
      st_r.mst      <= scf_pkg::SCF_MV_IDLE;
      st_r.wd_cnt   <= '0;
      st_r.wd_fired <= 1'b0;
      st_r.rdata    <= '0;
      st_r.irq      <= 1'b0;
      st_r.hold     <= '0;
      st_r.irq_out  <= '0;
      st_r.grant    <= 1'b0;
      st_r.start_ok <= 1'b0;
      st_r.bus_err  <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs, all straight from the state register
  // ---------------------------------------------------------------
  assign reg_rdata_o                     = st_r.rdata;
  assign periph_irq_o                    = st_r.irq_out;
  assign periph_hold_o                   = st_r.hold;
  assign internal_block_mover_grant_o    = st_r.grant;
  assign internal_block_mover_start_ok_o = st_r.start_ok;
  assign bus_error_o                     = st_r.bus_err;
  assign arb_low_latency_o               = st_r.arb_ll;
  // core disabled hands the bus and peripherals to the outside master
  assign ext_master_sel_o                = st_r.cpu_dis;
  assign core_disable_o                  = st_r.cpu_dis;
  assign core_clock_stop_o               = st_r.standby;
  assign irq_o                           = st_r.irq;

endmodule // scf_system_control

// ===== testbench/scf_chk.sv
`timescale 1ns/1ps
module scf_chk (
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic [3:0]  reg_addr_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic        debug_hold_n_i,
  input wire logic        ext_reset_n_i,
  input wire logic [3:0]  periph_irq_i,
  input wire logic [3:0]  periph_irq_o,
  input wire logic [3:0]  periph_hold_o,
  input wire logic        internal_block_mover_req_i,
  input wire logic        internal_block_mover_cycle_i,
  input wire logic        internal_block_mover_grant_o,
  input wire logic        internal_block_mover_start_ok_o,
  input wire logic        ext_master_sel_o,
  input wire logic        core_disable_o,
  input wire logic        core_clock_stop_o
);
  // ----------------------------------------
  // port relations
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_rd_idle; !reg_rd_i |=> reg_rdata_o == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  property p_wake;
    core_clock_stop_o && !reg_wr_i && (periph_irq_i & ~periph_hold_o) != 4'h0 ##1 $stable(periph_hold_o)
      |-> !core_clock_stop_o;
  endproperty
  a_wake: assert property (p_wake) else $error("standby kept after irq");
  property p_cpu; ext_reset_n_i [*4] |=> $stable(core_disable_o); endproperty
  a_cpu: assert property (p_cpu) else $error("core disable moved outside reset");
  property p_ext; ext_master_sel_o == core_disable_o; endproperty
  a_ext: assert property (p_ext) else $error("bus master select differs");
  property p_hold; debug_hold_n_i [*5] |-> periph_hold_o == 4'h0; endproperty
  a_hold: assert property (p_hold) else $error("hold without freeze");
  property p_gate; (periph_irq_o & periph_hold_o) == 4'h0; endproperty
  a_gate: assert property (p_gate) else $error("held peripheral irq");
  property p_drain;
    internal_block_mover_grant_o && internal_block_mover_cycle_i && internal_block_mover_req_i
      |=> internal_block_mover_grant_o;
  endproperty
  a_drain: assert property (p_drain) else $error("grant cut mid cycle");
  property p_start;
    !debug_hold_n_i [*5] ##0 periph_hold_o[0] |-> !internal_block_mover_start_ok_o;
  endproperty
  a_start: assert property (p_start) else $error("start allowed while frozen");
  property p_resume; (internal_block_mover_req_i && debug_hold_n_i) [*8] |-> internal_block_mover_grant_o;
  endproperty
  a_resume: assert property (p_resume) else $error("no grant after release");
  c_wake: cover property (core_clock_stop_o ##1 !core_clock_stop_o);
  c_drain: cover property (internal_block_mover_grant_o && !internal_block_mover_start_ok_o);
  c_cpu: cover property ($rose(core_disable_o));
endmodule // scf_chk

// ===== testbench/scf_partner.sv
`timescale 1ns/1ps
module scf_partner #(
  parameter int unsigned CYC_LEN = 4
) (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [3:0] irq_cmd_i,
  input  wire logic       want_i,
  input  wire logic       grant_i,
  input  wire logic       start_ok_i,
  output logic      [3:0] irq_o,
  output logic            req_o,
  output logic            cycle_o
);
  // ----------------------------------------
  // peripherals and block mover
  // ----------------------------------------
  logic [3:0] cnt_r;
  // gating while frozen is the device's job, so requests pass raw
  assign irq_o = irq_cmd_i;
  // an open cycle keeps the request up so it is never cut short
  assign req_o = want_i | cycle_o;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r   <= 4'h0;
      cycle_o <= 1'b0;
    end else if (cycle_o) begin
      cnt_r   <= cnt_r - 4'h1;
      cycle_o <= (cnt_r != 4'h1);
    end else if (want_i && grant_i && start_ok_i) begin
      cnt_r   <= CYC_LEN[3:0];
      cycle_o <= 1'b1;
    end
  end
endmodule // scf_partner

// ===== testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  // ----------------------------------------
  // stimulus and checks
  // ----------------------------------------
  logic        clk_i = 1'b0, rst_n_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0, mv_want = 1'b0;
  logic        debug_hold_n_i = 1'b1, ext_reset_n_i = 1'b1, ext_halt_n_i = 1'b1;
  logic [3:0]  reg_addr_i = 4'h0, irq_cmd = 4'h0, periph_irq_i, periph_irq_o, periph_hold_o;
  logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o;
  logic        internal_block_mover_req_i, internal_block_mover_cycle_i, irq_o;
  logic        internal_block_mover_grant_o, internal_block_mover_start_ok_o;
  logic        ext_master_sel_o, core_disable_o, core_clock_stop_o;
  logic        bus_cyc = 1'b0, bus_err, arb_ll;
  int          miscompares = 0, n_tests = 0, k;
  always #20 clk_i = ~clk_i;
  scf_system_control dut_u (.clk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .debug_hold_n_i, .ext_reset_n_i, .ext_halt_n_i, .periph_irq_i, .periph_irq_o,
    .periph_hold_o, .internal_block_mover_req_i, .internal_block_mover_cycle_i,
    .internal_block_mover_grant_o, .internal_block_mover_start_ok_o, .bus_cycle_i(bus_cyc),
    .bus_error_o(bus_err), .arb_low_latency_o(arb_ll), .ext_master_sel_o, .core_disable_o, .core_clock_stop_o,
    .irq_o);
  scf_partner part_u (.clk_i, .rst_n_i, .irq_cmd_i(irq_cmd), .want_i(mv_want),
    .grant_i(internal_block_mover_grant_o), .start_ok_i(internal_block_mover_start_ok_o),
    .irq_o(periph_irq_i), .req_o(internal_block_mover_req_i), .cycle_o(internal_block_mover_cycle_i));
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 chk(reg_rdata_o, e);
  endtask
  // bounded wait on the mover grant; running out ends the run
  task automatic wait_grant(input logic v);
    k = 0;
    while (internal_block_mover_grant_o !== v && k < 40) begin
      @(posedge clk_i);
      #1 k++;
    end
    if (k == 40) begin
      miscompares++;
      end_sim();
    end
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(4'h0, 32'h00000f1c);
    rd(4'h4, 32'h00000000);
    wr(4'h8, 32'hffffffff);
    rd(4'h8, 32'h00000000);
    rd(4'h0, 32'h00000f1c);
    wr(4'h4, 32'hffffffff);
    rd(4'h4, 32'hff000000);
    $display("registers test done");
    wr(4'h0, 32'h00000f1d);
    @(posedge clk_i);
    #1 chk(core_clock_stop_o, 1'b1);
    rd(4'h0, 32'h00010f1d);
    irq_cmd <= 4'h4;
    repeat (3) @(posedge clk_i);
    #1 chk(core_clock_stop_o, 1'b0);
    chk(periph_irq_o, 4'h4);
    chk(irq_o, 1'b1);
    rd(4'h0, 32'h01000f1c);
    irq_cmd <= 4'h0;
    wr(4'h0, 32'h01000f1c);
    rd(4'h0, 32'h00000f1c);
    chk(irq_o, 1'b0);
    $display("standby test done");
    mv_want <= 1'b1;
    wait_grant(1'b1);
    repeat (2) @(posedge clk_i);
    debug_hold_n_i <= 1'b0;
    irq_cmd        <= 4'hf;
    wait_grant(1'b0);
    chk(internal_block_mover_cycle_i, 1'b0);
    repeat (4) @(posedge clk_i);
    #1 chk(periph_hold_o, 4'hf);
    chk(periph_irq_o, 4'h0);
    chk(internal_block_mover_start_ok_o, 1'b0);
    chk(internal_block_mover_grant_o, 1'b0);
    rd(4'h0, 32'h02040f1c);
    irq_cmd        <= 4'h0;
    debug_hold_n_i <= 1'b1;
    wait_grant(1'b1);
    rd(4'h0, 32'h06080f1c);
    chk(periph_hold_o, 4'h0);
    wr(4'h0, 32'h06000f1c);
    mv_want <= 1'b0;
    wr(4'h0, 32'h0000001c);
    debug_hold_n_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    #1 chk(periph_hold_o, 4'h0);
    rd(4'h0, 32'h0204001c);
    debug_hold_n_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    wr(4'h0, 32'h06000f1c);
    rd(4'h0, 32'h00000f1c);
    $display("freeze test done");
    wr(4'h0, 32'h00000f06);
    #1 chk(arb_ll, 1'b1);
    bus_cyc <= 1'b1;
    k = 0;
    while (bus_err !== 1'b1 && k < 200) begin
      @(posedge clk_i);
      #1 k++;
    end
    chk(k, scf_pkg::WD_BASE_CYC);
    if (k == 200) end_sim();
    @(posedge clk_i);
    #1 chk(bus_err, 1'b0);
    bus_cyc <= 1'b0;
    rd(4'h0, 32'h10000f06);
    wr(4'h0, 32'h10000f1c);
    rd(4'h0, 32'h00000f1c);
    $display("watchdog test done");
    ext_reset_n_i <= 1'b0;
    ext_halt_n_i  <= 1'b0;
    repeat (5) @(posedge clk_i);
    ext_reset_n_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    ext_halt_n_i <= 1'b1;
    #1 chk(core_disable_o, 1'b1);
    chk(ext_master_sel_o, 1'b1);
    rd(4'h0, 32'h08020f1c);
    wr(4'h0, 32'h08000f1c);
    ext_reset_n_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    ext_reset_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    #1 chk(core_disable_o, 1'b0);
    $display("core disable test done");
    end_sim();
  end
endmodule // tb_top
bind scf_system_control scf_chk chk_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .debug_hold_n_i(debug_hold_n_i),
  .ext_reset_n_i(ext_reset_n_i), .periph_irq_i(periph_irq_i), .periph_irq_o(periph_irq_o),
  .periph_hold_o(periph_hold_o), .internal_block_mover_req_i(internal_block_mover_req_i),
  .internal_block_mover_cycle_i(internal_block_mover_cycle_i),
  .internal_block_mover_grant_o(internal_block_mover_grant_o),
  .internal_block_mover_start_ok_o(internal_block_mover_start_ok_o), .ext_master_sel_o(ext_master_sel_o),
  .core_disable_o(core_disable_o), .core_clock_stop_o(core_clock_stop_o));
